// ---- fsct_pkg.sv ----
// Shared constants for the configuration and fan period register block.
// Assumes one clock; register offsets are byte addresses of the register port.
package fsct_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] ADDR_CFG      = 8'h03;
    localparam logic [7:0] ADDR_ONE_SHOT = 8'h0F;
    localparam logic [7:0] ADDR_CRIT     = 8'h19;
    localparam logic [7:0] ADDR_TACH_LO  = 8'h46;
    localparam logic [7:0] ADDR_TACH_HI  = 8'h47;

    // ==========================================================
    // Configuration fields
    localparam int CFG_ALERT_MASK = 7;
    localparam int CFG_STANDBY    = 6;
    localparam int CFG_PWM_OFF    = 5;
    localparam int CFG_TACH_SEL   = 2;
    localparam int CFG_CRIT_OVR   = 1;
    localparam int CFG_FAULT_Q    = 0;
    localparam logic [7:0] CFG_WMASK = 8'hE7;

    // ==========================================================
    // Reset values and counts
    localparam logic [7:0] CFG_RESET     = 8'h00;
    localparam logic [7:0] CRIT_RESET    = 8'h55;
    localparam logic [1:0] QUEUE_DEPTH   = 2'h3;
    localparam logic [1:0] SINGLE_DEPTH  = 2'h1;
    localparam int         TACH_DIV_DFLT = 4;

    // ==========================================================
    // Conversion sequencer states
    typedef enum logic [0:0] {
        FSCT_IDLE = 1'b0,
        FSCT_BUSY = 1'b1
    } fsct_conv_t;

endpackage

// ---- fsct_tach_if.sv ----
// Carrier between the register block and the fan period meter.
// Assumes the strobes are one-cycle pulses on the register clock.
`timescale 1ns/1ps
`default_nettype none

interface fsct_tach_if;
    logic       lo_rd;
    logic       hi_rd;
    logic [7:0] lo_byte;
    logic [7:0] hi_byte;

    modport meter (
        input  lo_rd,
        input  hi_rd,
        output lo_byte,
        output hi_byte
    );
    modport regs (
        output lo_rd,
        output hi_rd,
        input  lo_byte,
        input  hi_byte
    );
endinterface

`default_nettype wire

// ---- fsct_alarm_filter.sv ----
// Remote out-of-range filter: one or three consecutive results raise alarm.
// Assumes i_done pulses once per finished remote conversion.
`timescale 1ns/1ps
`default_nettype none

module fsct_alarm_filter (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_reset_n,
    // Conversion results
    input  wire logic i_done,
    input  wire logic i_out_of_range,
    input  wire logic i_queue_en,
    // Alarm level
    output logic      o_alarm
);
    logic [1:0] cnt_r;
    logic [1:0] cnt_nxt;
    logic [1:0] need;
    logic       cnt_full;

    // ==========================================================
    // Consecutive count
    assign cnt_full = (cnt_r == fsct_pkg::QUEUE_DEPTH);
    assign cnt_nxt  = !i_done         ? cnt_r :
                      !i_out_of_range ? 2'h0  :
                      cnt_full        ? cnt_r : 2'(cnt_r + 2'h1);
    assign need     = i_queue_en ? fsct_pkg::QUEUE_DEPTH
                                 : fsct_pkg::SINGLE_DEPTH;
    assign o_alarm  = (cnt_r >= need);

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt_r <= 2'h0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // ==========================================================
    // Checks
    property p_single_alarm;
        @(posedge i_clk) disable iff (!i_reset_n)
        (!i_queue_en && i_done && i_out_of_range) ##1 !i_queue_en
            |-> o_alarm;
    endproperty
    a_single_alarm: assert property (p_single_alarm)
        else $error("single out-of-range result gave no alarm");

    property p_queue_wait;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_queue_en && i_done && i_out_of_range && cnt_r == 2'h0)
            ##1 i_queue_en |-> !o_alarm;
    endproperty
    a_queue_wait: assert property (p_queue_wait)
        else $error("queued alarm raised after one result");
endmodule

`default_nettype wire

// ---- fsct_tach_meter.sv ----
// Fan period meter with low-byte read lock of the high byte.
// Assumes the tach input is synchronous to i_clk.
`timescale 1ns/1ps
`default_nettype none

module fsct_tach_meter #(
    parameter int TACH_DIV = fsct_pkg::TACH_DIV_DFLT
) (
    // Clock and reset
    input  wire logic  i_clk,
    input  wire logic  i_reset_n,
    // Tach pulse input
    input  wire logic  i_tach,
    // Register side
    fsct_tach_if.meter bus
);
    localparam int DW = $clog2(TACH_DIV + 1);

    generate
        if (TACH_DIV < 1) begin : g_bad_div
            $error("TACH_DIV must be at least 1");
        end
    endgenerate

    logic [DW-1:0] div_r;
    logic [13:0]   per_r;
    logic [15:0]   count_r;
    logic [7:0]    frozen_r;
    logic          lock_r;
    logic          tach_q_r;
    logic          edge_seen;
    logic          tick;
    logic          per_full;

    // ==========================================================
    // Period measurement in units of four count ticks
    assign edge_seen   = i_tach && !tach_q_r;
    assign tick        = (div_r == DW'(TACH_DIV - 1));
    assign per_full    = (per_r == 14'h3FFF);
    assign bus.lo_byte = count_r[7:0];
    assign bus.hi_byte = lock_r ? frozen_r : count_r[15:8];

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            div_r    <= '0;
            per_r    <= 14'h0000;
            count_r  <= 16'h0000;
            tach_q_r <= 1'b0;
        end else begin
            tach_q_r <= i_tach;
            div_r    <= tick ? '0 : DW'(div_r + 1'b1);
            if (edge_seen) begin
                count_r <= {per_r, 2'h0};
                per_r   <= 14'h0000;
            end else if (tick && !per_full) begin
                per_r <= 14'(per_r + 14'h0001);
            end
        end
    end

    // ==========================================================
    // Read lock
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            frozen_r <= 8'h00;
            lock_r   <= 1'b0;
        end else if (bus.lo_rd) begin
            frozen_r <= count_r[15:8];
            lock_r   <= 1'b1;
        end else if (bus.hi_rd) begin
            lock_r <= 1'b0;
        end
    end

    // ==========================================================
    // Checks
    property p_lo_bits;
        @(posedge i_clk) disable iff (!i_reset_n)
        bus.lo_byte[1:0] == 2'h0;
    endproperty
    a_lo_bits: assert property (p_lo_bits)
        else $error("low count bits not zero");

    property p_lock_hold;
        @(posedge i_clk) disable iff (!i_reset_n)
        bus.lo_rd ##1 !bus.hi_rd
            |-> bus.hi_byte == $past(count_r[15:8]);
    endproperty
    a_lock_hold: assert property (p_lock_hold)
        else $error("high byte not frozen after low read");

    property p_release;
        @(posedge i_clk) disable iff (!i_reset_n)
        (bus.hi_rd && !bus.lo_rd) |=> !lock_r ##0
            bus.hi_byte == count_r[15:8];
    endproperty
    a_release: assert property (p_release)
        else $error("high byte still frozen after high read");
endmodule

`default_nettype wire

// ---- fsct_regs.sv ----
// Configuration, critical limit and fan period registers of the sensor.
// Assumes a register port already decoded from the management bus.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Config bit 7 set masks alarms and releases the alarm pin.
// - Bit 6 clear converts continuously; set enters standby, stopping conversions.
// - In standby any write to 0x0F starts exactly one conversion.
// - In standby with bit 5 set, the PWM pin holds its off level.
// - Config bits 4:3 read zero and do nothing.
// - Bit 2 set turns the shared pin into a released tach input.
// - Critical limit starts at 85; writes to 0x19 need bit 1 set.
// - After one change the critical limit is fixed until power-on reset.
// - Bit 0 chooses one or three consecutive out-of-range results for alarm.
// - Period count is 16 bits; low-byte read freezes the high byte.
// - Count measures tach pulse spacing; low byte valid only in 7:2.
module fsct_regs #(
    parameter int TACH_DIV = fsct_pkg::TACH_DIV_DFLT
) (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_reset_n,
    // Register port
    input  wire logic [7:0] i_reg_addr,
    input  wire logic       i_reg_wr,
    input  wire logic [7:0] i_reg_wdata,
    input  wire logic       i_reg_rd,
    output logic      [7:0] o_reg_rdata,
    // Conversion engine
    output logic            o_conv_start,
    input  wire logic       i_conv_done,
    input  wire logic       i_remote_oor,
    output logic            o_standby,
    output logic      [7:0] o_crit_limit,
    // Fan drive
    input  wire logic       i_pwm_wave,
    input  wire logic       i_pwm_pol,
    output logic            o_pwm_out,
    // Shared alarm / tach pin
    input  wire logic       i_alert_tach_i,
    output logic            o_alert_tach_o,
    output logic            o_alert_tach_oe
);
    fsct_tach_if tach_bus ();

    fsct_pkg::fsct_conv_t state_r;
    fsct_pkg::fsct_conv_t state_nxt;

    logic [7:0] cfg_r;
    logic [7:0] crit_r;
    logic       crit_done_r;
    logic       shot_pend_r;
    logic       start_r;
    logic       alert_r;
    logic       pwm_r;
    logic [7:0] rdata_r;

    // ==========================================================
    // Decode
    logic       wr_cfg;
    logic       wr_shot;
    logic       wr_crit;
    logic       crit_ok;
    logic       standby;
    logic       start;
    logic       alarm;
    logic       tach_sel;
    logic       pwm_hold;
    logic       pwm_off_lvl;
    logic       alert_nxt;
    logic [7:0] rdata_nxt;

    assign wr_cfg   = i_reg_wr && (i_reg_addr == fsct_pkg::ADDR_CFG);
    assign wr_shot  = i_reg_wr && (i_reg_addr == fsct_pkg::ADDR_ONE_SHOT);
    assign wr_crit  = i_reg_wr && (i_reg_addr == fsct_pkg::ADDR_CRIT);
    assign crit_ok  = cfg_r[fsct_pkg::CFG_CRIT_OVR] && !crit_done_r;
    assign standby  = cfg_r[fsct_pkg::CFG_STANDBY];
    assign tach_sel = cfg_r[fsct_pkg::CFG_TACH_SEL];

    assign tach_bus.lo_rd =
        i_reg_rd && (i_reg_addr == fsct_pkg::ADDR_TACH_LO);
    assign tach_bus.hi_rd =
        i_reg_rd && (i_reg_addr == fsct_pkg::ADDR_TACH_HI);

    assign rdata_nxt =
        (i_reg_addr == fsct_pkg::ADDR_CFG)     ? cfg_r            :
        (i_reg_addr == fsct_pkg::ADDR_CRIT)    ? crit_r           :
        (i_reg_addr == fsct_pkg::ADDR_TACH_LO) ? tach_bus.lo_byte :
        (i_reg_addr == fsct_pkg::ADDR_TACH_HI) ? tach_bus.hi_byte :
                                                 8'h00;

    // ==========================================================
    // Configuration and critical limit
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cfg_r <= fsct_pkg::CFG_RESET;
        end else if (wr_cfg) begin
            cfg_r <= i_reg_wdata & fsct_pkg::CFG_WMASK;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            crit_r      <= fsct_pkg::CRIT_RESET;
            crit_done_r <= 1'b0;
        end else if (wr_crit && crit_ok) begin
            crit_r      <= i_reg_wdata;
            crit_done_r <= 1'b1;
        end
    end

    // ==========================================================
    // Conversion sequencer
    // Continuous when awake, one pending shot when in standby.
    assign start = (state_r == fsct_pkg::FSCT_IDLE) &&
                   (!standby || shot_pend_r);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            fsct_pkg::FSCT_IDLE: begin
                if (start) begin
                    state_nxt = fsct_pkg::FSCT_BUSY;
                end
            end
            fsct_pkg::FSCT_BUSY: begin
                if (i_conv_done) begin
                    state_nxt = fsct_pkg::FSCT_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_r <= fsct_pkg::FSCT_IDLE;
            start_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            start_r <= start;
        end
    end

    // New shot request wins over the clear of an old one
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            shot_pend_r <= 1'b0;
        end else if (wr_shot && standby) begin
            shot_pend_r <= 1'b1;
        end else if (start || !standby) begin
            shot_pend_r <= 1'b0;
        end
    end

    // ==========================================================
    // Alarm filter and shared pin
    fsct_alarm_filter u_filter (
        .i_clk          (i_clk),
        .i_reset_n      (i_reset_n),
        .i_done         (i_conv_done),
        .i_out_of_range (i_remote_oor),
        .i_queue_en     (cfg_r[fsct_pkg::CFG_FAULT_Q]),
        .o_alarm        (alarm)
    );

    assign alert_nxt = alarm && !cfg_r[fsct_pkg::CFG_ALERT_MASK]
                       && !tach_sel;

    fsct_tach_meter #(
        .TACH_DIV (TACH_DIV)
    ) u_tach (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_tach    (i_alert_tach_i && tach_sel),
        .bus       (tach_bus)
    );

    // ==========================================================
    // Fan drive
    // Polarity high means active-high drive, so off is low.
    assign pwm_off_lvl = !i_pwm_pol;
    assign pwm_hold    = standby && cfg_r[fsct_pkg::CFG_PWM_OFF];

    // ==========================================================
    // Output registers
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            alert_r <= 1'b0;
            pwm_r   <= 1'b0;
            rdata_r <= 8'h00;
        end else begin
            alert_r <= alert_nxt;
            pwm_r   <= pwm_hold ? pwm_off_lvl : i_pwm_wave;
            if (i_reg_rd) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    assign o_reg_rdata     = rdata_r;
    assign o_conv_start    = start_r;
    assign o_standby       = standby;
    assign o_crit_limit    = crit_r;
    assign o_pwm_out       = pwm_r;
    assign o_alert_tach_o  = 1'b0;
    assign o_alert_tach_oe = alert_r;

    // ==========================================================
    // Checks
    sequence s_one_shot;
        o_conv_start ##1 !o_conv_start;
    endsequence

    sequence s_quiet_standby;
        standby && state_r == fsct_pkg::FSCT_IDLE && !shot_pend_r;
    endsequence

    property p_mask;
        @(posedge i_clk) disable iff (!i_reset_n)
        cfg_r[fsct_pkg::CFG_ALERT_MASK] |=> !o_alert_tach_oe;
    endproperty
    a_mask: assert property (p_mask)
        else $error("alarm pin driven while masked");

    property p_continuous;
        @(posedge i_clk) disable iff (!i_reset_n)
        (!standby && state_r == fsct_pkg::FSCT_IDLE) |=> o_conv_start;
    endproperty
    a_continuous: assert property (p_continuous)
        else $error("idle awake sequencer did not start");

    property p_shot;
        @(posedge i_clk) disable iff (!i_reset_n)
        (s_quiet_standby and (wr_shot && !wr_cfg)) |=> ##1 s_one_shot;
    endproperty
    a_shot: assert property (p_shot)
        else $error("standby shot write gave no single start");

    property p_no_shot;
        @(posedge i_clk) disable iff (!i_reset_n)
        (s_quiet_standby and !wr_shot) |=> !o_conv_start;
    endproperty
    a_no_shot: assert property (p_no_shot)
        else $error("conversion started in standby without request");

    property p_pwm_off;
        @(posedge i_clk) disable iff (!i_reset_n)
        pwm_hold |=> o_pwm_out == !$past(i_pwm_pol);
    endproperty
    a_pwm_off: assert property (p_pwm_off)
        else $error("fan drive not at off level in standby");

    property p_cfg_zero;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_reg_rd && i_reg_addr == fsct_pkg::ADDR_CFG)
            |=> o_reg_rdata[4:3] == 2'h0;
    endproperty
    a_cfg_zero: assert property (p_cfg_zero)
        else $error("unused config bits read nonzero");

    property p_tach_pin;
        @(posedge i_clk) disable iff (!i_reset_n)
        tach_sel |=> !o_alert_tach_oe;
    endproperty
    a_tach_pin: assert property (p_tach_pin)
        else $error("shared pin driven in tach mode");

    property p_crit_guard;
        @(posedge i_clk) disable iff (!i_reset_n)
        (wr_crit && !cfg_r[fsct_pkg::CFG_CRIT_OVR]) |=> $stable(crit_r);
    endproperty
    a_crit_guard: assert property (p_crit_guard)
        else $error("critical limit changed without override bit");

    property p_crit_once;
        @(posedge i_clk) disable iff (!i_reset_n)
        crit_done_r |=> $stable(crit_r) ##0 crit_done_r;
    endproperty
    a_crit_once: assert property (p_crit_once)
        else $error("critical limit changed twice");
endmodule

`default_nettype wire

// ---- fsct_conv_model.sv ----
// Conversion engine and fan tach source facing the register block.
// Assumes start pulses from the block; one conversion at a time.
`timescale 1ns/1ps
`default_nettype none

module fsct_conv_model #(
    parameter int CONV_LAT = 6
) (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    // Conversion handshake
    input  wire logic        i_conv_start,
    input  wire logic        i_oor,
    output logic             o_conv_done,
    output logic             o_remote_oor,
    // Fan tach source, zero period holds the pin high
    input  wire logic [15:0] i_tach_period,
    output logic             o_tach
);
    int lat_r;
    int ph_r;

    // ==========================================================
    // Conversion and tach timing
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            lat_r        <= 0;
            ph_r         <= 0;
            o_conv_done  <= 1'b0;
            o_remote_oor <= 1'b0;
            o_tach       <= 1'b1;
        end else begin
            o_conv_done  <= (lat_r == 1);
            // Result line meaningless outside done
            o_remote_oor <= (lat_r == 1) ? i_oor : ~o_remote_oor;
            if (lat_r != 0)
                lat_r <= lat_r - 1;
            else if (i_conv_start)
                lat_r <= CONV_LAT;
            if (i_tach_period == 16'h0000 || ph_r + 1 >= i_tach_period)
                ph_r <= 0;
            else
                ph_r <= ph_r + 1;
            o_tach <= (i_tach_period == 16'h0000) || (ph_r >= 2);
        end
    end
endmodule

`default_nettype wire

// ---- test_fan_sensor_config_tach_regs.sv ----
// Self-checking bench for the configuration and fan period registers.
// Assumes the decoded strobe register port and a 200 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module test_fan_sensor_config_tach_regs;
    logic        i_clk, i_reset_n, wr, rd, wave, pol, oor;
    logic [7:0]  addr, wdata, rdata, d, lo;
    logic        start, done, roor, pwm, pin_o, oe, tach, stby;
    logic [7:0]  crit;
    logic [15:0] period;
    int          miscompares, check_count, starts, cycles, n0;
    logic [7:0]  t_cfg [4] = '{8'h40, 8'h60, 8'h60, 8'h20};
    logic        t_pol [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    logic        t_wav [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    logic        t_exp [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

    fsct_regs #(.TACH_DIV(1)) fsct_regs_i (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_reg_addr(addr),
        .i_reg_wr(wr), .i_reg_wdata(wdata), .i_reg_rd(rd),
        .o_reg_rdata(rdata), .o_conv_start(start), .i_conv_done(done),
        .i_remote_oor(roor), .o_standby(stby), .o_crit_limit(crit),
        .i_pwm_wave(wave), .i_pwm_pol(pol), .o_pwm_out(pwm),
        .i_alert_tach_i(oe ? 1'b0 : tach), .o_alert_tach_o(pin_o),
        .o_alert_tach_oe(oe));
    fsct_conv_model fsct_conv_model_i (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_conv_start(start),
        .i_oor(oor), .o_conv_done(done), .o_remote_oor(roor),
        .i_tach_period(period), .o_tach(tach));

    // ==========================================================
    // Clock, start counter and timeout
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cycles++;
        if (start === 1'b1) starts++;
        if (cycles == 20000) begin
            miscompares++;
            summarize();
        end
    end

    // ==========================================================
    // Access and compare tasks
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge i_clk);
        addr <= a; wdata <= v; wr <= 1'b1;
        @(posedge i_clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        @(posedge i_clk);
        addr <= a; rd <= 1'b1;
        @(posedge i_clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic check8(input string n, input logic [7:0] e, g);
        check_count++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", n, e, g);
            miscompares++;
        end
    endtask
    task automatic check1(input string n, input logic e, g);
        check_count++;
        if (g !== e) begin
            $display("unexpected %s expected %b seen %b", n, e, g);
            miscompares++;
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    // Alarm pin two edges after a conversion with the current result
    task automatic done_oe(input string n, input logic e);
        int k;
        k = 0;
        do begin
            @(posedge i_clk);
            k++;
        end while ((done !== 1'b1 || roor !== oor) && k < 50);
        wait_cyc(2);
        check1(n, e, oe);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ==========================================================
    // Tests
    initial begin
        i_reset_n = 1'b0; addr = 8'h00; wdata = 8'h00; wr = 1'b0;
        rd = 1'b0; wave = 1'b0; pol = 1'b1; oor = 1'b0;
        period = 16'h0000; miscompares = 0; check_count = 0;
        starts = 0; cycles = 0;
        repeat (2) @(posedge i_clk);
        i_reset_n <= 1'b1;
        rd_reg(fsct_pkg::ADDR_CFG, d);
        check8("cfg reset", fsct_pkg::CFG_RESET, d);
        rd_reg(8'h20, d);
        check8("unmapped read", 8'h00, d);
        check1("alarm pin reset", 1'b0, oe);
        check1("pin drive level", 1'b0, pin_o);
        $display("test reset done");
        wr_reg(fsct_pkg::ADDR_CRIT, 8'h40);
        rd_reg(fsct_pkg::ADDR_CRIT, d);
        check8("crit locked", fsct_pkg::CRIT_RESET, d);
        wr_reg(fsct_pkg::ADDR_CFG, 8'h02);
        wr_reg(fsct_pkg::ADDR_CRIT, 8'h40);
        rd_reg(fsct_pkg::ADDR_CRIT, d);
        check8("crit changed", 8'h40, d);
        wr_reg(fsct_pkg::ADDR_CRIT, 8'h30);
        rd_reg(fsct_pkg::ADDR_CRIT, d);
        check8("crit second", 8'h40, d);
        check8("crit port", 8'h40, crit);
        $display("test critical limit done");
        wr_reg(fsct_pkg::ADDR_CFG, 8'hFF);
        rd_reg(fsct_pkg::ADDR_CFG, d);
        check8("cfg unused bits", fsct_pkg::CFG_WMASK, d);
        check1("standby port", 1'b1, stby);
        wr_reg(fsct_pkg::ADDR_CFG, 8'h00);
        n0 = starts;
        wait_cyc(60);
        check1("continuous", 1'b1, starts - n0 >= 3);
        wr_reg(fsct_pkg::ADDR_CFG, 8'h40);
        wait_cyc(20);
        n0 = starts;
        wait_cyc(60);
        check8("standby starts", 8'h00, 8'(starts - n0));
        wr_reg(fsct_pkg::ADDR_ONE_SHOT, 8'h5A);
        wait_cyc(30);
        check8("single shot", 8'h01, 8'(starts - n0));
        $display("test conversions done");
        for (int i = 0; i < 4; i++) begin
            wr_reg(fsct_pkg::ADDR_CFG, t_cfg[i]);
            pol <= t_pol[i];
            wave <= t_wav[i];
            wait_cyc(3);
            check1("pwm out", t_exp[i], pwm);
        end
        $display("test pwm done");
        wr_reg(fsct_pkg::ADDR_CFG, 8'h00);
        oor <= 1'b1;
        done_oe("alarm single", 1'b1);
        wr_reg(fsct_pkg::ADDR_CFG, 8'h80);
        wait_cyc(2);
        check1("alarm masked", 1'b0, oe);
        done_oe("alarm masked run", 1'b0);
        wr_reg(fsct_pkg::ADDR_CFG, 8'h04);
        done_oe("alarm tach mode", 1'b0);
        wr_reg(fsct_pkg::ADDR_CFG, 8'h00);
        done_oe("alarm again", 1'b1);
        oor <= 1'b0;
        done_oe("alarm cleared", 1'b0);
        wr_reg(fsct_pkg::ADDR_CFG, 8'h01);
        oor <= 1'b1;
        done_oe("queue first", 1'b0);
        done_oe("queue second", 1'b0);
        done_oe("queue third", 1'b1);
        oor <= 1'b0;
        $display("test alarm done");
        wr_reg(fsct_pkg::ADDR_CFG, 8'h04);
        period <= 16'd100;
        wait_cyc(300);
        rd_reg(fsct_pkg::ADDR_TACH_LO, lo);
        period <= 16'd200;
        wait_cyc(500);
        rd_reg(fsct_pkg::ADDR_TACH_HI, d);
        check8("frozen high", 8'h01, d);
        rd_reg(fsct_pkg::ADDR_TACH_HI, d);
        check8("live high", 8'h03, d);
        rd_reg(fsct_pkg::ADDR_TACH_LO, lo);
        rd_reg(fsct_pkg::ADDR_TACH_HI, d);
        check8("pair high", 8'h03, d);
        check1("low bits", 1'b0, |lo[1:0]);
        check1("period", 1'b1, {d, lo} >= 16'd792 && {d, lo} <= 16'd804);
        $display("test fan period done");
        summarize();
    end
endmodule

`default_nettype wire
